// [logic/pcc_call_seq.sv]
// Procedure-call sequencer: checks, faults and stack pushes behind APB
`default_nettype none
module pcc_call_seq (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [pcc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       push_valid,
  input  wire logic                  push_ready,
  output pcc_pkg::pcc_push_t         push_item,
  output logic                       task_switch
);
  import pcc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_LOAD, S_PUSH, S_FIN} pcc_state_t;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0] cfg_q [NREG];
  pcc_state_t  st_q;
  logic [31:0] res_eip_q;
  logic [15:0] res_cs_q;
  logic [15:0] res_ss_q;
  logic [1:0]  res_cpl_q;
  logic        far_q;
  logic        mp_q;
  logic        task_q;
  logic        w32_q;
  logic [4:0]  np_q;
  logic [5:0]  npush_q;
  logic [5:0]  pi_q;
  logic [31:0] wsp_q;
  logic        done_q;
  logic [2:0]  flt_q;
  logic [15:0] err_q;
  logic        tsw_q;
  logic [31:0] tsa_q;
  logic [31:0] prdata_q;
  logic        tswp_q;
  pcc_push_t   item_q;

  function automatic logic is_null(input logic [15:0] s);
    is_null = (s[15:2] == 14'h0000);
  endfunction

  function automatic logic sel_out(input logic [15:0] s, input logic [31:0] lim);
    if (s[SEL_TI]) sel_out = (s[15:3] > lim[LDT_LO +: 13]);
    else sel_out = (s[15:3] > lim[12:0]);
  endfunction

  function automatic logic [31:0] m16(input logic [31:0] v, input logic wide);
    m16 = wide ? v : (v & IP16_MASK);
  endfunction

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire [4:0] ix      = paddr[6:2];
  wire       mapped  = (paddr <= OFF_TSA) && (paddr[1:0] == 2'b00);
  wire       wr_acc  = psel && penable && pwrite && mapped;
  wire       idle    = (st_q == S_IDLE);
  // Writes during a call are dropped so the snapshot stays stable
  wire       wr_ok   = wr_acc && idle && (ix < 5'(NREG));
  wire       start   = wr_ok && (ix == OFF_CTRL[6:2]) && pwdata[CTL_START];
  wire [31:0] stat   = {err_q, 10'h000, tsw_q, flt_q, done_q, !idle};
  wire [31:0] rd_cfg = (ix < 5'(NREG)) ? cfg_q[ix] : 32'h0000_0000;
  wire [31:0] rd_val = (ix == OFF_STAT[6:2]) ? stat :
                       (ix == OFF_TSA[6:2])  ? tsa_q : rd_cfg;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // ------------------------------------------------------------------
  // Operand views
  // ------------------------------------------------------------------
  wire [31:0] ctrl  = cfg_q[OFF_CTRL[6:2]];
  wire [1:0]  kind  = ctrl[CTL_KIND +: 2];
  wire        op32  = ctrl[CTL_OP32];
  wire        tss32 = ctrl[CTL_TSS32];
  wire [1:0]  current_privilege_level   = ctrl[CTL_CPL +: 2];
  wire [31:0] toff  = cfg_q[OFF_TOFF[6:2]];
  wire [31:0] tsel  = cfg_q[OFF_TSEL[6:2]];
  wire [31:0] ext_instruction_pointer   = cfg_q[OFF_EIP[6:2]];
  wire [31:0] segs  = cfg_q[OFF_SEGS[6:2]];
  wire [31:0] sp    = cfg_q[OFF_SP[6:2]];
  wire [31:0] room  = cfg_q[OFF_ROOM[6:2]];
  wire [31:0] clim  = cfg_q[OFF_CLIM[6:2]];
  wire [31:0] dlim  = cfg_q[OFF_DLIM[6:2]];
  wire [31:0] gate  = cfg_q[OFF_GATE[6:2]];
  wire [31:0] goff  = cfg_q[OFF_GOFF[6:2]];
  wire [31:0] task_state_block   = cfg_q[OFF_TSS[6:2]];
  wire [31:0] nstk  = cfg_q[OFF_NSTK[6:2]];
  wire [31:0] nroom = cfg_q[OFF_NRM[6:2]];
  wire [31:0] nsp   = cfg_q[OFF_NSP[6:2]];
  wire [31:0] lims  = cfg_q[OFF_LIMS[6:2]];
  pcc_desc_t  d;
  pcc_desc_t  c;
  pcc_desc_t  ssd;
  assign d   = cfg_q[OFF_DESC[6:2]][7:0];
  assign c   = cfg_q[OFF_CODE[6:2]][7:0];
  assign ssd = nstk[SSD_LO +: 8];

  // Protected mode only with the v86 flag clear
  wire        real_far = !ctrl[CTL_PE] || ctrl[CTL_VM];
  // 16-bit far targets carry the selector in bits 31:16
  wire [15:0] sel   = op32 ? tsel[15:0] : toff[31:16];
  wire [1:0]  requested_privilege_level   = sel[1:0];
  wire [31:0] offm  = m16(toff, op32);
  wire        d_code = d.typ[TY_S] && d.typ[TY_EXE];
  wire        d_conf = d_code && d.typ[TY_CONF];
  wire        d_cg   = (d.typ == TY_CG16) || (d.typ == TY_CG32);
  wire        d_tg   = (d.typ == TY_TGATE);
  wire        d_tss  = ((d.typ & TSS_MASK) == TSS_MATCH);
  wire        c_code = c.typ[TY_S] && c.typ[TY_EXE];
  wire        gw32   = (d.typ == TY_CG32);
  wire [15:0] gsel   = gate[15:0];
  wire [4:0]  np     = gate[PCNT_LO +: 5];
  wire [31:0] goffm  = m16(goff, gw32);
  wire        gdpl_bad = (d.descriptor_privilege_level < current_privilege_level) || (d.descriptor_privilege_level < requested_privilege_level);
  // Only a lower nonconforming target switches stacks
  wire        mp     = !c.typ[TY_CONF] && (c.descriptor_privilege_level < current_privilege_level);
  wire [15:0] nss    = nstk[15:0];
  wire        ss_wr  = ssd.typ[TY_S] && !ssd.typ[TY_EXE] && ssd.typ[TY_WR];
  // New stack location in the task block
  wire [15:0] tsa32  = {11'h000, c.descriptor_privilege_level, 3'b000} + TSA_ADD32;
  wire [15:0] tsa16  = {12'h000, c.descriptor_privilege_level, 2'b00} + TSA_ADD16;
  wire [15:0] tsa    = tss32 ? tsa32 : tsa16;
  wire [15:0] tsa_nd = tsa + (tss32 ? TSA_END32 : TSA_END16);
  wire [15:0] tsa_sl = tsa + (tss32 ? TSA_SEL32 : TSA_SEL16);
  wire        tsa_bad = (tsa_nd > task_state_block[15:0]);
  wire [31:0] pbytes = gw32 ? {25'h0, np, 2'b00} : {26'h0, np, 1'b0};
  wire [31:0] need_mp = pbytes + (gw32 ? NEED_MP32 : NEED_MP16);
  wire [31:0] need_sp = gw32 ? NEED_SP32 : (pbytes + NEED_SP16);
  wire [31:0] need_n  = op32 ? NEED_N32 : NEED_N16;
  wire [31:0] need_f  = op32 ? NEED_F32 : NEED_F16;
  wire [31:0] rel_sum = ext_instruction_pointer + toff;

  // ------------------------------------------------------------------
  // Checks, in priority order; first failure wins
  // ------------------------------------------------------------------
  logic [2:0]  flt;
  logic [15:0] ferr;
  logic [31:0] r_eip;
  logic [15:0] r_cs;
  logic [15:0] r_ss;
  logic [1:0]  r_cpl;
  logic        r_far;
  logic        r_mp;
  logic        r_task;
  logic        r_w32;
  logic [5:0]  r_npush;

  always_comb begin
    flt     = F_NONE;
    ferr    = 16'h0000;
    r_eip   = ext_instruction_pointer;
    r_cs    = segs[15:0];
    r_ss    = segs[31:16];
    r_cpl   = current_privilege_level;
    r_far   = 1'b0;
    r_mp    = 1'b0;
    r_task  = 1'b0;
    r_w32   = op32;
    r_npush = 6'd1;
    case (kind)
      K_NEAR_REL, K_NEAR_ABS: begin
        if (ext_instruction_pointer > clim) {flt, ferr} = {F_GP, 16'h0000};
        else if (room < need_n) {flt, ferr} = {F_SS, 16'h0000};
        else if (kind == K_NEAR_REL) r_eip = m16(rel_sum, op32);
        else r_eip = offm;
      end
      K_FAR: begin
        r_far   = 1'b1;
        r_npush = 6'd2;
        if (real_far) begin
          if (room < need_f) {flt, ferr} = {F_SS, 16'h0000};
          else if (ext_instruction_pointer > clim) {flt, ferr} = {F_GP, 16'h0000};
          r_cs  = sel;
          r_eip = offm;
        end else if (is_null(sel)) {flt, ferr} = {F_GP, 16'h0000};
        else if (sel_out(sel, lims)) {flt, ferr} = {F_GP, sel};
        else if (!(d_code || d_cg || d_tg || d_tss)) {flt, ferr} = {F_GP, sel};
        else if (d_code) begin
          // Both code kinds load the selector with REQUESTED_PRIVILEGE_LEVEL forced to CURRENT_PRIVILEGE_LEVEL
          r_cs  = {sel[15:2], current_privilege_level};
          r_eip = offm;
          if (d_conf && d.descriptor_privilege_level > current_privilege_level) {flt, ferr} = {F_GP, sel};
          else if (!d_conf && (requested_privilege_level > current_privilege_level || d.descriptor_privilege_level != current_privilege_level)) {flt, ferr} = {F_GP, sel};
          else if (!d.pres) {flt, ferr} = {F_NP, sel};
          else if (room < need_f) {flt, ferr} = {F_SS, 16'h0000};
          else if (offm > dlim) {flt, ferr} = {F_GP, 16'h0000};
        end else if (d_cg) begin
          r_w32   = gw32;
          r_mp    = mp;
          r_npush = mp ? 6'd4 + {1'b0, np} : 6'd2;
          r_eip   = goffm;
          r_cs    = mp ? {gsel[15:2], c.descriptor_privilege_level} : {gsel[15:2], current_privilege_level};
          r_ss    = mp ? nss : segs[31:16];
          r_cpl   = mp ? c.descriptor_privilege_level : current_privilege_level;
          if (gdpl_bad) {flt, ferr} = {F_GP, sel};
          else if (!d.pres) {flt, ferr} = {F_NP, sel};
          else if (is_null(gsel)) {flt, ferr} = {F_GP, 16'h0000};
          else if (sel_out(gsel, lims)) {flt, ferr} = {F_GP, gsel};
          else if (!c_code || c.descriptor_privilege_level > current_privilege_level) {flt, ferr} = {F_GP, gsel};
          else if (!c.pres) {flt, ferr} = {F_NP, gsel};
          else if (mp && tsa_bad) {flt, ferr} = {F_TS, task_state_block[31:16]};
          else if (mp && is_null(nss)) {flt, ferr} = {F_TS, nss};
          else if (mp && sel_out(nss, lims)) {flt, ferr} = {F_TS, nss};
          else if (mp && (nss[1:0] != c.descriptor_privilege_level || ssd.descriptor_privilege_level != c.descriptor_privilege_level || !ss_wr))
            {flt, ferr} = {F_TS, nss};
          else if (mp && !ssd.pres) {flt, ferr} = {F_SS, nss};
          else if (mp && nroom < need_mp) {flt, ferr} = {F_SS, nss};
          else if (!mp && room < need_sp) {flt, ferr} = {F_SS, 16'h0000};
          else if (goffm > dlim) {flt, ferr} = {F_GP, 16'h0000};
        end else if (d_tg) begin
          r_task  = 1'b1;
          r_npush = 6'd0;
          if (gdpl_bad) {flt, ferr} = {F_GP, sel};
          else if (!d.pres) {flt, ferr} = {F_NP, sel};
          else if (gsel[SEL_TI] || sel_out(gsel, lims)) {flt, ferr} = {F_GP, gsel};
          else if (c.typ == TSS_BUSY) {flt, ferr} = {F_GP, gsel};
          else if (!c.pres) {flt, ferr} = {F_NP, gsel};
        end else begin
          r_task  = 1'b1;
          r_npush = 6'd0;
          if (gdpl_bad || d.typ == TSS_BUSY) {flt, ferr} = {F_GP, sel};
          else if (!d.pres) {flt, ferr} = {F_NP, sel};
        end
      end
      default: begin
        // Post-switch pointer check, run once the new task is loaded
        r_npush = 6'd0;
        if (ext_instruction_pointer > clim) {flt, ferr} = {F_GP, 16'h0000};
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  wire        ok      = (flt == F_NONE);
  wire        last    = (pi_q + 6'd1 == npush_q);
  wire [31:0] wstep   = w32_q ? 32'h0000_0004 : 32'h0000_0002;
  wire [31:0] wsp_nx  = wsp_q - wstep;
  wire [5:0]  par_end = 6'd2 + {1'b0, np_q};
  wire        is_par  = mp_q && (pi_q >= 6'd2) && (pi_q < par_end);
  wire [31:0] pdata   = (mp_q && pi_q == 6'd0) ? {16'h0000, segs[31:16]} :
                        (mp_q && pi_q == 6'd1) ? sp :
                        is_par ? {26'h0, pi_q - 6'd2} :
                        (far_q && pi_q + 6'd2 == npush_q) ? {16'h0000, segs[15:0]} :
                        m16(ext_instruction_pointer, w32_q);

  assign push_valid  = (st_q == S_PUSH);
  assign push_item   = item_q;
  assign task_switch = tswp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
    end else begin
      case (st_q)
        S_IDLE:  if (start) st_q <= S_CHECK;
        // No push happens unless every check has passed
        S_CHECK: st_q <= !ok ? S_IDLE : (r_npush == 6'd0) ? S_FIN : S_LOAD;
        S_LOAD:  st_q <= S_PUSH;
        S_PUSH:  if (push_ready) st_q <= last ? S_FIN : S_LOAD;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {res_eip_q, res_cs_q, res_ss_q, res_cpl_q} <= '0;
      {far_q, mp_q, task_q, w32_q, np_q, npush_q} <= '0;
    end else if (st_q == S_CHECK) begin
      {res_eip_q, res_cs_q, res_ss_q, res_cpl_q} <= {r_eip, r_cs, r_ss, r_cpl};
      {far_q, mp_q, task_q, w32_q} <= {r_far, r_mp, r_task, r_w32};
      np_q    <= np;
      npush_q <= r_npush;
    end
  end

  // Stack pushes, old stack pair first on a level raise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wsp_q  <= REG_RST;
      pi_q   <= 6'd0;
      item_q <= '0;
    end else if (st_q == S_CHECK) begin
      wsp_q <= r_mp ? nsp : sp;
      pi_q  <= 6'd0;
    end else if (st_q == S_LOAD) begin
      wsp_q  <= wsp_nx;
      item_q <= '{addr: wsp_nx, data: pdata, wide: w32_q, param: is_par};
    end else if (st_q == S_PUSH && push_ready) begin
      pi_q <= pi_q + 6'd1;
    end
  end

  // ------------------------------------------------------------------
  // Status
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {done_q, flt_q, err_q, tsw_q, tswp_q} <= '0;
      tsa_q <= REG_RST;
    end else begin
      tswp_q <= (st_q == S_FIN) && task_q;
      if (start) begin
        {done_q, flt_q, err_q, tsw_q} <= '0;
      end else if (st_q == S_CHECK) begin
        tsa_q  <= {tsa_sl, tsa};
        flt_q  <= flt;
        err_q  <= ferr;
        done_q <= !ok;
      end else if (st_q == S_FIN) begin
        done_q <= 1'b1;
        tsw_q  <= task_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= REG_RST;
    else if (psel && !penable) prdata_q <= rd_val;
  end

  // ------------------------------------------------------------------
  // Register file; commit in S_FIN after any pushes, none on a task switch
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) cfg_q[i] <= REG_RST;
    end else if (wr_ok) begin
      cfg_q[ix] <= pwdata & wmask(ix);
    end else if (st_q == S_FIN && !task_q) begin
      cfg_q[OFF_EIP[6:2]] <= res_eip_q;
      cfg_q[OFF_SP[6:2]]  <= wsp_q;
      // Near calls keep the code segment
      if (far_q) cfg_q[OFF_SEGS[6:2]] <= {res_ss_q, res_cs_q};
      cfg_q[OFF_CTRL[6:2]][CTL_CPL +: 2] <= res_cpl_q;
    end
  end

endmodule // pcc_call_seq
`default_nettype wire

// [logic/pcc_pkg.sv]
// Constants, register layout and carrier types of the procedure-call sequencer
`default_nettype none
package pcc_pkg;

  // ------------------------------------------------------------------
  // Register map, byte offsets on the APB
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NREG     = 18;
  localparam logic [7:0]  OFF_CTRL = 8'h00;
  localparam logic [7:0]  OFF_TOFF = 8'h04;
  localparam logic [7:0]  OFF_TSEL = 8'h08;
  localparam logic [7:0]  OFF_EIP  = 8'h0C;
  localparam logic [7:0]  OFF_SEGS = 8'h10;
  localparam logic [7:0]  OFF_SP   = 8'h14;
  localparam logic [7:0]  OFF_ROOM = 8'h18;
  localparam logic [7:0]  OFF_CLIM = 8'h1C;
  localparam logic [7:0]  OFF_DLIM = 8'h20;
  localparam logic [7:0]  OFF_DESC = 8'h24;
  localparam logic [7:0]  OFF_GATE = 8'h28;
  localparam logic [7:0]  OFF_GOFF = 8'h2C;
  localparam logic [7:0]  OFF_CODE = 8'h30;
  localparam logic [7:0]  OFF_TSS  = 8'h34;
  localparam logic [7:0]  OFF_NSTK = 8'h38;
  localparam logic [7:0]  OFF_NRM  = 8'h3C;
  localparam logic [7:0]  OFF_NSP  = 8'h40;
  localparam logic [7:0]  OFF_LIMS = 8'h44;
  localparam logic [7:0]  OFF_STAT = 8'h48;
  localparam logic [7:0]  OFF_TSA  = 8'h4C;
  localparam logic [31:0] REG_RST  = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned CTL_START = 0;
  localparam int unsigned CTL_KIND  = 1;
  localparam int unsigned CTL_OP32  = 3;
  localparam int unsigned CTL_PE    = 4;
  localparam int unsigned CTL_VM    = 5;
  localparam int unsigned CTL_TSS32 = 6;
  localparam int unsigned CTL_CPL   = 8;
  localparam int unsigned PCNT_LO   = 16;
  localparam int unsigned SSD_LO    = 16;
  localparam int unsigned LDT_LO    = 16;
  localparam int unsigned SEL_TI    = 2;
  localparam int unsigned TY_S      = 4;
  localparam int unsigned TY_EXE    = 3;
  localparam int unsigned TY_CONF   = 2;
  localparam int unsigned TY_WR     = 1;
  localparam int unsigned ST_FAULT  = 2;

  // ------------------------------------------------------------------
  // Write masks; bits outside read as zero
  // ------------------------------------------------------------------
  localparam logic [31:0] MSK_CTRL = 32'h0000_037E;
  localparam logic [31:0] MSK_16   = 32'h0000_FFFF;
  localparam logic [31:0] MSK_8    = 32'h0000_00FF;
  localparam logic [31:0] MSK_GATE = 32'h001F_FFFF;
  localparam logic [31:0] MSK_NSTK = 32'h00FF_FFFF;
  localparam logic [31:0] MSK_LIMS = 32'h1FFF_1FFF;
  localparam logic [31:0] MSK_ALL  = 32'hFFFF_FFFF;

  // ------------------------------------------------------------------
  // Descriptor types, stack needs and task block layout
  // ------------------------------------------------------------------
  localparam logic [4:0]  TY_CG16   = 5'h04;
  localparam logic [4:0]  TY_CG32   = 5'h0C;
  localparam logic [4:0]  TY_TGATE  = 5'h05;
  localparam logic [4:0]  TSS_MASK  = 5'h15;
  localparam logic [4:0]  TSS_MATCH = 5'h01;
  localparam logic [4:0]  TSS_BUSY  = 5'h01;
  localparam logic [31:0] IP16_MASK = 32'h0000_FFFF;
  localparam logic [31:0] NEED_N32  = 32'h0000_0004;
  localparam logic [31:0] NEED_N16  = 32'h0000_0002;
  localparam logic [31:0] NEED_F32  = 32'h0000_0006;
  localparam logic [31:0] NEED_F16  = 32'h0000_0004;
  localparam logic [31:0] NEED_MP32 = 32'h0000_0010;
  localparam logic [31:0] NEED_MP16 = 32'h0000_0008;
  localparam logic [31:0] NEED_SP32 = 32'h0000_0008;
  localparam logic [31:0] NEED_SP16 = 32'h0000_0004;
  localparam logic [15:0] TSA_ADD32 = 16'h0004;
  localparam logic [15:0] TSA_END32 = 16'h0007;
  localparam logic [15:0] TSA_SEL32 = 16'h0004;
  localparam logic [15:0] TSA_ADD16 = 16'h0002;
  localparam logic [15:0] TSA_END16 = 16'h0004;
  localparam logic [15:0] TSA_SEL16 = 16'h0002;

  localparam logic [2:0]  F_NONE = 3'h0;
  localparam logic [2:0]  F_GP   = 3'h1;
  localparam logic [2:0]  F_SS   = 3'h2;
  localparam logic [2:0]  F_NP   = 3'h3;
  localparam logic [2:0]  F_TS   = 3'h4;

  typedef enum logic [1:0] {K_NEAR_REL, K_NEAR_ABS, K_FAR, K_RESUME} pcc_kind_t;

  typedef struct packed {
    logic       pres;
    logic [1:0] descriptor_privilege_level;
    logic [4:0] typ;
  } pcc_desc_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        wide;
    logic        param;
  } pcc_push_t;

  function automatic logic [31:0] wmask(input logic [4:0] ix);
    if (ix == OFF_CTRL[6:2]) wmask = MSK_CTRL;
    else if (ix == OFF_TSEL[6:2]) wmask = MSK_16;
    else if (ix == OFF_DESC[6:2] || ix == OFF_CODE[6:2]) wmask = MSK_8;
    else if (ix == OFF_GATE[6:2]) wmask = MSK_GATE;
    else if (ix == OFF_NSTK[6:2]) wmask = MSK_NSTK;
    else if (ix == OFF_LIMS[6:2]) wmask = MSK_LIMS;
    else wmask = MSK_ALL;
  endfunction

endpackage
`default_nettype wire

// [bench/pcc_props.sv]
// Port timing checker of the procedure-call sequencer
`default_nettype none
module pcc_props (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [pcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       push_valid,
  input wire logic                       push_ready,
  input wire pcc_pkg::pcc_push_t         push_item,
  input wire logic                       task_switch
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcc_pkg::*;
  // ---
  // Decode of the access phase
  // ---
  wire logic acc_w;
  wire logic bad_w;
  assign acc_w = psel && penable;
  assign bad_w = paddr > 8'h4C || paddr[1:0] != 2'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (pready) else $error("pready low");
  AST_ERR: assert property (acc_w && bad_w |-> pslverr) else $error("pslverr missing");
  AST_NOERR: assert property (!(acc_w && bad_w) |-> !pslverr) else $error("stray pslverr");
  AST_HOLD: assert property (push_valid && !push_ready |=> push_valid && $stable(push_item))
    else $error("push changed before accept");
  AST_PULSE: assert property (task_switch |=> !task_switch) else $error("long pulse");
  AST_TSNP: assert property (task_switch |-> !push_valid) else $error("push on switch");
  AST_PRD: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
  AST_RST: assert property ($rose(presetn) |-> !push_valid && !task_switch)
    else $error("busy after reset");
endmodule // pcc_props
bind pcc_call_seq pcc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .push_valid, .push_ready, .push_item, .task_switch);
`default_nettype wire

// [bench/pcc_mem_model.sv]
// Stack memory model: takes pushes, stalls at random when slow
`default_nettype none
module pcc_mem_model (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               slow,
  input  wire logic               push_valid,
  input  wire pcc_pkg::pcc_push_t push_item,
  output logic                    push_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcc_pkg::*;
  pcc_push_t q [$];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) push_ready <= 1'b0;
    else begin
      if (push_valid && push_ready) q.push_back(push_item);
      push_ready <= !slow || ($urandom % 3 == 0);
    end
  end
endmodule // pcc_mem_model
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench of the procedure-call sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pcc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, slow, err, op, ab, fl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, e, t, x, nd;
  logic        pready, pslverr, push_valid, push_ready, task_switch;
  pcc_push_t   push_item;
  int          n_errors, checks_done, cyc, n_ts;
  logic [15:0] sel [4] = '{16'h0, 16'h8, 16'h8, 16'h8};
  logic [7:0]  dsc [4] = '{8'h9A, 8'hBA, 8'hE9, 8'hE1};
  logic [31:0] st [4] = '{32'h6, 32'h8_0006, 32'h22, 32'h8_0006};
  logic [39:0] cg [10] = '{{OFF_TSEL, 32'hB}, {OFF_DESC, 32'hEC}, {OFF_GATE, 32'h1_0010},
    {OFF_GOFF, 32'h100}, {OFF_CODE, 32'h9A}, {OFF_TSS, 32'h28_0067},
    {OFF_NSTK, 32'h92_0018}, {OFF_NSP, 32'h9000}, {OFF_DLIM, 32'hFFFF_FFFF},
    {OFF_SEGS, 32'h20_0033}};
  pcc_call_seq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .push_valid, .push_ready, .push_item, .task_switch);
  pcc_mem_model mem (.pclk, .presetn, .slow, .push_valid, .push_item, .push_ready);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ---
  // Hang guard well above the expected run length
  // ---
  always @(posedge pclk) begin
    n_ts <= n_ts + (task_switch === 1'b1);
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic prep(input logic [31:0] ei, sp, rm, lim, tof);
    apb(1'b1, OFF_EIP, ei);
    apb(1'b1, OFF_SP, sp);
    apb(1'b1, OFF_ROOM, rm);
    apb(1'b1, OFF_CLIM, lim);
    apb(1'b1, OFF_TOFF, tof);
  endtask
  // Polls done; a lost done shows up as a status mismatch later
  task automatic call(input logic [31:0] c);
    int n;
    mem.q.delete();
    n_ts = 0;
    apb(1'b1, OFF_CTRL, c | 32'h1);
    n = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 40);
  endtask
  task automatic res(input logic [31:0] s, ei, np);
    cmp("status", s, rd);
    apb(1'b0, OFF_EIP, 32'h0);
    cmp("eip", ei, rd);
    cmp("pushes", np, 32'(mem.q.size()));
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, presetn} = '0;
    {n_errors, checks_done, cyc, n_ts} = '0;
    void'($urandom(32'h3eed));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 'h54; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      cmp("slverr", 32'(a > 'h4C), 32'(err));
      if (a < 'h50) cmp("reset value", 32'h0, rd);
    end
    // Near calls: relative/absolute, both sizes, pass and fault
    for (int i = 0; i < 8; i++) begin
      {fl, ab, op} = 3'(i);
      e = ($urandom & 32'hFFFF) | 32'h1;
      t = $urandom;
      nd = op ? NEED_N32 : NEED_N16;
      prep(e, 32'h8000, (fl && !ab) ? nd - 1 : nd, (fl && ab) ? e - 1 : 32'hFFFF_FFFF, t);
      call(32'(ab) << 1 | 32'(op) << 3);
      x = ab ? t : e + t;
      if (!op) x = x & IP16_MASK;
      if (fl) res(ab ? 32'h6 : 32'hA, e, 0);
      else begin
        res(32'h2, x, 1);
        cmp("push data", op ? e : e & IP16_MASK, mem.q[0].data);
        cmp("push wide", 32'(op), 32'(mem.q[0].wide));
      end
      apb(1'b0, OFF_SP, 32'h0);
      cmp("sp", fl ? 32'h8000 : 32'h8000 - nd, rd);
      apb(1'b0, OFF_SEGS, 32'h0);
      cmp("segs", 32'h0, rd);
    end
    // Real and v86 far calls with a stalling stack
    for (int i = 0; i < 4; i++) begin
      op = i[0];
      e = $urandom;
      t = $urandom;
      apb(1'b1, OFF_SEGS, 32'h1234);
      apb(1'b1, OFF_TSEL, 32'h5678);
      prep(e, 32'h8000, NEED_F32, 32'hFFFF_FFFF, t);
      slow <= 1'b1;
      call(32'h4 | 32'(op) << 3 | (i[1] ? 32'h30 : 32'h0));
      slow <= 1'b0;
      res(32'h2, op ? t : t & IP16_MASK, 2);
      cmp("push cs", 32'h1234, mem.q[0].data);
      cmp("push eip", op ? e : e & IP16_MASK, mem.q[1].data);
      apb(1'b0, OFF_SEGS, 32'h0);
      cmp("cs", op ? 32'h5678 : {16'h0, t[31:16]}, {16'h0, rd[15:0]});
    end
    // Protected: null selector, bad level, task block free and busy
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_TSEL, {16'h0, sel[i]});
      apb(1'b1, OFF_DESC, {24'h0, dsc[i]});
      apb(1'b1, OFF_LIMS, 32'h000A_000A);
      prep(32'h40, 32'h8000, 32'h40, 32'hFFFF_FFFF, 32'h10);
      call(32'h1C);
      res(st[i], 32'h40, 0);
      cmp("task switch", 32'(i == 2), 32'(n_ts));
    end
    // Level-raising call gate: short new stack faults, then full copy with one parameter
    foreach (cg[k]) apb(1'b1, cg[k][39:32], cg[k][31:0]);
    prep(32'h40, 32'h8000, 32'h40, 32'hFFFF_FFFF, 32'h10);
    apb(1'b1, OFF_NRM, 32'h13);
    call(32'h35C);
    res(32'h18_000A, 32'h40, 0);
    apb(1'b1, OFF_NRM, 32'h40);
    call(32'h35C);
    res(32'h2, 32'h100, 5);
    cmp("push ss", 32'h20, mem.q[0].data);
    cmp("push sp", 32'h8000, mem.q[1].data);
    cmp("push param", 32'h1, 32'(mem.q[2].param));
    cmp("push eip", 32'h40, mem.q[4].data);
    cmp("push addr", 32'h8FEC, mem.q[4].addr);
    apb(1'b0, OFF_SEGS, 32'h0);
    cmp("segs", 32'h18_0010, rd);
    apb(1'b0, OFF_CTRL, 32'h0);
    cmp("level", 32'h5C, rd);
    apb(1'b0, OFF_TSA, 32'h0);
    cmp("task block addr", 32'h8_0004, rd);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
